// *** verilog/program_memory_code_protect.sv ***
`timescale 1ns/1ps
`include "code_protect_consts.svh"
module program_memory_code_protect #(
  parameter int BLOCKS = 4             // Numbered program blocks
) (
  input  wire logic                           clk,          // 40 MHz core clock
  input  wire logic                           rst_b,        // Async reset, low
  input  wire code_protect_pkg::table_req_t   cpuReq,       // Core table access
  input  wire logic [21:0]                    cpuPc,        // Executing instruction address
  input  wire code_protect_pkg::table_req_t   progReq,      // External programmer access
  input  wire logic                           progBlockErase, // Erase pulse for block
  input  wire logic [2:0]                     progEraseIdx, // Block to erase, 4 = boot
  input  wire logic                           progChipErase, // Full chip erase pulse
  input  wire logic                           hvEntryPin,   // High-voltage entry level
  input  wire logic                           progSelectPin, // Programming-select pin in
  input  wire logic [7:0]                     memRdata,     // Array read data, same clock
  output code_protect_pkg::table_rsp_t        cpuRsp,       // Answer to core
  output code_protect_pkg::table_rsp_t        progRsp,      // Answer to programmer
  output logic [7:0]                          tableLatch,   // Core table latch
  output logic                                memWriteEn,   // Commit write to array
  output logic [21:0]                         memAddr,      // Array address
  output logic [7:0]                          memWdata,     // Array write data
  output logic                                progMode,     // Programming mode active
  output logic                                progSelectDedicated, // Pin owned by programming
  output logic                                progSelectPullupEn,  // Pin pull-up enable
  output logic                                debugEnable   // Debugger resources reserved
);
  // ==========================================================
  // Protection configuration bytes
  logic [BLOCKS-1:0] blockCodeLock;
  logic [BLOCKS-1:0] blockWriteLock;
  logic [BLOCKS-1:0] blockCrossReadEnable;
  logic              bootCodeLock;
  logic              bootWriteLock;
  logic              bootCrossReadEnable;
  logic              eepromCodeLock;
  logic              eepromWriteLock;
  logic              configWriteLock;
  logic [7:0]        debugProgOptions;
  logic [7:0]        idBytes [8];
  logic              pinMeta;
  logic              pinSync;
  logic              hvMeta;
  logic              hvSync;
  logic              hvEntered;

  // ==========================================================
  // Address decode for core and programmer
  logic [2:0] cpuBlk, pcBlk, progBlk;
  logic       cpuInUser, pcInUser, progInUser;

  protect_block_decode uCpuDec (
    .addr     (cpuReq.addr),
    .blockIdx (cpuBlk),
    .inUser   (cpuInUser)
  );
  protect_block_decode uPcDec (
    .addr     (cpuPc),
    .blockIdx (pcBlk),
    .inUser   (pcInUser)
  );
  protect_block_decode uProgDec (
    .addr     (progReq.addr),
    .blockIdx (progBlk),
    .inUser   (progInUser)
  );

  // Region classification, used by both requesters
  function automatic code_protect_pkg::region_t region_of(input logic [21:0] a,
                                                          input logic eep);
    if (eep)
      return code_protect_pkg::REG_EEPROM;
    else if (a < `USER_TOP)
      return code_protect_pkg::REG_BLK;
    else if (a >= `ID_BASE && a <= `ID_LAST)
      return code_protect_pkg::REG_ID;
    else if (a >= `CFG_BASE && a <= `CFG_LAST)
      return code_protect_pkg::REG_CFG;
    else if (a >= `DEVID_BASE && a <= `DEVID_LAST)
      return code_protect_pkg::REG_DEVID;
    else
      return code_protect_pkg::REG_EMPTY;
  endfunction

  // Per-block bit select, index 4 is the boot block
  function automatic logic pick(input logic [2:0] idx, input logic [BLOCKS-1:0] v,
                                input logic boot);
    if (idx == 3'h4)
      return boot;
    else
      return v[idx[1:0]];
  endfunction

  // Readback of the protection byte at an address
  function automatic logic [7:0] cfg_byte(input logic [21:0] a);
    logic [7:0] b;
    b = 8'h00;
    if (a == `CFG_CODE_LO)
      b[3:0] = blockCodeLock;
    else if (a == `CFG_CODE_HI)
      b = {eepromCodeLock, bootCodeLock, 6'h00};
    else if (a == `CFG_WRITE_LO)
      b[3:0] = blockWriteLock;
    else if (a == `CFG_WRITE_HI)
      b = {eepromWriteLock, bootWriteLock, configWriteLock, 5'h00};
    else if (a == `CFG_XREAD_LO)
      b[3:0] = blockCrossReadEnable;
    else if (a == `CFG_XREAD_HI)
      b = {1'b0, bootCrossReadEnable, 6'h00};
    else if (a == `CFG_DEBUG_PROG)
      b = debugProgOptions;
    return b;
  endfunction

  code_protect_pkg::region_t cpuRegion, progRegion;
  assign cpuRegion  = region_of(cpuReq.addr, cpuReq.eeprom);
  assign progRegion = region_of(progReq.addr, progReq.eeprom);

  // Core checks: code locks ignored here, so no lock of that kind is read
  logic cpuSameBlk, cpuReadOk, cpuWriteOk;
  assign cpuSameBlk = pcInUser && (pcBlk == cpuBlk);
  always_comb
  begin
    cpuReadOk  = 1'b1;
    cpuWriteOk = 1'b1;
    case (cpuRegion)
      code_protect_pkg::REG_BLK:
      begin
        cpuReadOk  = pick(cpuBlk, blockCrossReadEnable, bootCrossReadEnable)
                     || cpuSameBlk;
        cpuWriteOk = pick(cpuBlk, blockWriteLock, bootWriteLock);
      end
      code_protect_pkg::REG_EMPTY:
      begin
        cpuReadOk  = 1'b0;
        cpuWriteOk = 1'b0;
      end
      code_protect_pkg::REG_CFG:
        cpuWriteOk = configWriteLock
                     && cpuReq.addr != `CFG_WRITE_HI;
      code_protect_pkg::REG_DEVID:
        cpuWriteOk = 1'b0;
      default:
      begin
        cpuReadOk  = 1'b1;
        cpuWriteOk = 1'b1;
      end
    endcase
  end

  // Programmer checks: code locks and EEPROM locks apply here only
  logic progReadOk, progWriteOk;
  always_comb
  begin
    progReadOk  = 1'b1;
    progWriteOk = 1'b1;
    case (progRegion)
      code_protect_pkg::REG_BLK:
      begin
        progReadOk  = pick(progBlk, blockCodeLock, bootCodeLock);
        progWriteOk = progReadOk && pick(progBlk, blockWriteLock, bootWriteLock);
      end
      code_protect_pkg::REG_EEPROM:
      begin
        progReadOk  = eepromCodeLock;
        progWriteOk = eepromCodeLock && eepromWriteLock;
      end
      code_protect_pkg::REG_EMPTY:
      begin
        progReadOk  = 1'b0;
        progWriteOk = 1'b0;
      end
      code_protect_pkg::REG_CFG:
        progWriteOk = configWriteLock || progReq.addr == `CFG_WRITE_HI;
      code_protect_pkg::REG_DEVID:
        progWriteOk = 1'b0;
      default:
      begin
        progReadOk  = 1'b1;
        progWriteOk = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      hvMeta  <= 1'b0;
      hvSync  <= 1'b0;
    end
    else
    begin
      pinMeta <= progSelectPin;
      pinSync <= pinMeta;
      hvMeta  <= hvEntryPin;
      hvSync  <= hvMeta;
    end
  end

  // Programming entry; high voltage always wins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hvEntered <= 1'b0;
      progMode  <= 1'b0;
    end
    else
    begin
      hvEntered <= hvSync;
      progMode  <= hvSync || (debugProgOptions[`F_LVP] && pinSync);
    end
  end

  // Pin ownership and debugger enable follow the option byte
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      progSelectDedicated <= 1'b1;
      progSelectPullupEn  <= 1'b0;
      debugEnable         <= 1'b0;
    end
    else
    begin
      progSelectDedicated <= debugProgOptions[`F_LVP];
      progSelectPullupEn  <= !debugProgOptions[`F_LVP];
      debugEnable         <= !debugProgOptions[`F_DEBUG];
    end
  end

  // ==========================================================
  // Protection bit storage: lock writes clear only, erase sets; option byte writes set or clear
  logic progWr, cpuWr;
  assign progWr = progMode && progReq.write && progWriteOk;
  assign cpuWr  = !progMode && cpuReq.write && cpuWriteOk;
  logic [21:0] cfgA;
  logic [7:0]  cfgD;
  assign cfgA = progWr ? progReq.addr : cpuReq.addr;
  assign cfgD = progWr ? progReq.wdata : cpuReq.wdata;
  // Region keeps the data memory flag, so such writes never hit config bytes
  code_protect_pkg::region_t wrRegion;
  assign wrRegion = progWr ? progRegion : cpuRegion;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blockCodeLock        <= '1;
      blockWriteLock       <= '1;
      blockCrossReadEnable <= '1;
      bootCodeLock         <= 1'b1;
      bootWriteLock        <= 1'b1;
      bootCrossReadEnable  <= 1'b1;
      eepromCodeLock       <= 1'b1;
      eepromWriteLock      <= 1'b1;
      configWriteLock      <= 1'b1;
      debugProgOptions     <= `DEBUG_PROG_INIT;
    end
    else if (progMode && progChipErase)
    begin
      blockCodeLock        <= '1;
      blockWriteLock       <= '1;
      blockCrossReadEnable <= '1;
      bootCodeLock         <= 1'b1;
      bootWriteLock        <= 1'b1;
      bootCrossReadEnable  <= 1'b1;
      eepromCodeLock       <= 1'b1;
      eepromWriteLock      <= 1'b1;
      configWriteLock      <= 1'b1;
    end
    else if (progMode && progBlockErase)
    begin
      if (progEraseIdx == 3'h4)
      begin
        bootCodeLock        <= 1'b1;
        bootWriteLock       <= 1'b1;
        bootCrossReadEnable <= 1'b1;
      end
      else
      begin
        blockCodeLock[progEraseIdx[1:0]]        <= 1'b1;
        blockWriteLock[progEraseIdx[1:0]]       <= 1'b1;
        blockCrossReadEnable[progEraseIdx[1:0]] <= 1'b1;
      end
    end
    else if ((progWr || cpuWr) && wrRegion == code_protect_pkg::REG_CFG)
    begin
      // And-ing keeps a zero bit at zero
      if (cfgA == `CFG_CODE_LO)
        blockCodeLock <= blockCodeLock & cfgD[3:0];
      else if (cfgA == `CFG_CODE_HI)
      begin
        eepromCodeLock <= eepromCodeLock & cfgD[`F_EEPROM_CODE];
        bootCodeLock   <= bootCodeLock & cfgD[`F_BOOT_CODE];
      end
      else if (cfgA == `CFG_WRITE_LO)
        blockWriteLock <= blockWriteLock & cfgD[3:0];
      else if (cfgA == `CFG_WRITE_HI && progWr)
      begin
        eepromWriteLock <= eepromWriteLock & cfgD[`F_EEPROM_WRITE];
        bootWriteLock   <= bootWriteLock & cfgD[`F_BOOT_WRITE];
        configWriteLock <= configWriteLock & cfgD[`F_CONFIG_WRITE];
      end
      else if (cfgA == `CFG_XREAD_LO)
        blockCrossReadEnable <= blockCrossReadEnable & cfgD[3:0];
      else if (cfgA == `CFG_XREAD_HI)
        bootCrossReadEnable <= bootCrossReadEnable & cfgD[`F_BOOT_XREAD];
      else if (cfgA == `CFG_DEBUG_PROG)
      begin
        debugProgOptions[7:3] <= cfgD[7:3];
        debugProgOptions[1:0] <= cfgD[1:0];
        if (progWr && hvEntered)
          debugProgOptions[`F_LVP] <= cfgD[`F_LVP];
      end
    end
  end

  // ID bytes: open to both sides, never locked
  always_ff @(posedge clk)
  begin
    if ((progWr || cpuWr) && wrRegion == code_protect_pkg::REG_ID)
      idBytes[cfgA[2:0]] <= cfgD;
  end

  // ==========================================================
  // Answers and array commit; refused writes only ack
  logic [7:0] cpuData, progData;
  assign cpuData  = (cpuRegion == code_protect_pkg::REG_CFG) ? cfg_byte(cpuReq.addr) :
                    (cpuRegion == code_protect_pkg::REG_ID) ? idBytes[cpuReq.addr[2:0]] :
                    memRdata;
  assign progData = (progRegion == code_protect_pkg::REG_CFG) ? cfg_byte(progReq.addr) :
                    (progRegion == code_protect_pkg::REG_ID) ? idBytes[progReq.addr[2:0]] :
                    memRdata;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpuRsp     <= '0;
      progRsp    <= '0;
      tableLatch <= 8'h00;
      memWriteEn <= 1'b0;
      memAddr    <= 22'h000000;
      memWdata   <= 8'h00;
    end
    else
    begin
      cpuRsp.ack      <= !progMode && (cpuReq.read || cpuReq.write);
      cpuRsp.allowed  <= cpuReq.write ? cpuWriteOk : cpuReadOk;
      cpuRsp.rdata    <= (cpuReq.read && cpuReadOk) ? cpuData : 8'h00;
      progRsp.ack     <= progMode && (progReq.read || progReq.write);
      progRsp.allowed <= progReq.write ? progWriteOk : progReadOk;
      progRsp.rdata   <= (progReq.read && progReadOk) ? progData : 8'h00;
      if (!progMode && cpuReq.read && !cpuReq.eeprom)
        tableLatch <= cpuReadOk ? cpuData : 8'h00;
      memWriteEn <= (progWr || cpuWr) && (wrRegion == code_protect_pkg::REG_BLK ||
                                          wrRegion == code_protect_pkg::REG_EEPROM);
      memAddr    <= progMode ? progReq.addr : cpuReq.addr;
      memWdata   <= cfgD;
    end
  end
endmodule

// *** verilog/code_protect_consts.svh ***
`ifndef CODE_PROTECT_CONSTS_SVH
`define CODE_PROTECT_CONSTS_SVH
// ==========================================================
// Address map
`define BOOT_END        22'h0001FF
`define BLK0_BASE       22'h000200
`define BLK1_BASE       22'h002000
`define BLK2_BASE       22'h004000
`define BLK3_BASE       22'h006000
`define USER_TOP        22'h008000
`define ID_BASE         22'h200000
`define ID_LAST         22'h200007
`define CFG_CODE_LO     22'h300008
`define CFG_CODE_HI     22'h300009
`define CFG_WRITE_LO    22'h30000A
`define CFG_WRITE_HI    22'h30000B
`define CFG_XREAD_LO    22'h30000C
`define CFG_XREAD_HI    22'h30000D
`define CFG_DEBUG_PROG  22'h300006
`define CFG_BASE        22'h300000
`define CFG_LAST        22'h30000F
`define DEVID_BASE      22'h3FFFFE
`define DEVID_LAST      22'h3FFFFF
// ==========================================================
// Field positions
`define F_EEPROM_CODE   7
`define F_BOOT_CODE     6
`define F_EEPROM_WRITE  7
`define F_BOOT_WRITE    6
`define F_CONFIG_WRITE  5
`define F_BOOT_XREAD    6
`define F_DEBUG         7
`define F_LVP           2
// Erased value and the low-voltage enable leaves the factory set
`define CFG_ERASED      8'hFF
`define DEBUG_PROG_INIT 8'h85
`endif

// *** verilog/code_protect_pkg.sv ***
package code_protect_pkg;
  // Memory region a table address falls into
  typedef enum logic [6:0] {
    REG_BLK    = 7'h01,
    REG_EMPTY  = 7'h02,
    REG_ID     = 7'h04,
    REG_CFG    = 7'h08,
    REG_DEVID  = 7'h10,
    REG_EEPROM = 7'h20,
    REG_NONE   = 7'h40
  } region_t;

  // One table access request
  typedef struct packed {
    logic        read;
    logic        write;
    logic        eeprom;
    logic [21:0] addr;
    logic [7:0]  wdata;
  } table_req_t;

  // Answer to an access
  typedef struct packed {
    logic       ack;
    logic       allowed;
    logic [7:0] rdata;
  } table_rsp_t;
endpackage

// *** verilog/protect_block_decode.sv ***
`timescale 1ns/1ps
`include "code_protect_consts.svh"
// Maps a program address to its protection block, 0..3 = numbered, 4 = boot
module protect_block_decode (
  input  wire logic [21:0] addr,    // Program memory address
  output logic      [2:0]  blockIdx, // Block index, 4 = boot
  output logic             inUser    // Address is implemented user memory
);
  // ==========================================================
  // Block boundaries
  always_comb
  begin
    inUser   = (addr < `USER_TOP);
    if (addr <= `BOOT_END)
      blockIdx = 3'h4;
    else if (addr < `BLK1_BASE)
      blockIdx = 3'h0;
    else if (addr < `BLK2_BASE)
      blockIdx = 3'h1;
    else if (addr < `BLK3_BASE)
      blockIdx = 3'h2;
    else
      blockIdx = 3'h3;
  end
endmodule

// *** dv/code_protect_properties.sv ***
`timescale 1ns/1ps
// ==========================================
// Port-level checks of the protection unit
module code_protect_properties (
  input wire logic                         clk,                 // Core clock
  input wire logic                         rst_b,               // Async reset, low
  input wire code_protect_pkg::table_req_t cpuReq,              // Core access
  input wire logic                         hvEntryPin,          // High-voltage entry
  input wire code_protect_pkg::table_rsp_t cpuRsp,              // Core answer
  input wire logic [7:0]                   tableLatch,          // Core latch
  input wire logic                         memWriteEn,          // Array commit
  input wire logic                         progMode,            // Programming mode
  input wire logic                         progSelectDedicated, // Pin owned
  input wire logic                         progSelectPullupEn   // Pin pull-up
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Core request taken this edge; core is ignored while programming
  logic cpuGo;
  logic cpuRd;
  assign cpuGo = !progMode && (cpuReq.read || cpuReq.write);
  assign cpuRd = cpuGo && cpuReq.read && !cpuReq.eeprom;

  // ==========================================
  // Core handshake
  chk_core_ack_next: assert property (
    cpuGo |=> cpuRsp.ack)
    else $error("core access not answered one cycle later");
  chk_core_muted: assert property (
    progMode |=> !cpuRsp.ack)
    else $error("core answered during programming mode");
  chk_eeprom_free: assert property (
    cpuGo && cpuReq.eeprom |=> cpuRsp.ack && cpuRsp.allowed)
    else $error("core data memory access refused");

  // ==========================================
  // Read gating and latch
  chk_empty_zero: assert property (
    cpuRd && cpuReq.addr inside {[22'h008000:22'h1FFFFF]}
    |=> cpuRsp.rdata == 8'h00 && tableLatch == 8'h00)
    else $error("unimplemented space read not zero");
  chk_id_readable: assert property (
    cpuRd && cpuReq.addr inside {[22'h200000:22'h200007]} |=> cpuRsp.allowed)
    else $error("identification byte read refused");
  chk_latch_hold: assert property (
    !(cpuGo && cpuReq.read) |=> $stable(tableLatch))
    else $error("table latch moved without a read");

  // ==========================================
  // Write refusal and pin ownership
  chk_cfg_lock_core: assert property (
    cpuGo && cpuReq.write && cpuReq.addr == 22'h30000B
    |=> cpuRsp.ack && !cpuRsp.allowed)
    else $error("core changed the config write lock byte");
  chk_refused_quiet: assert property (
    cpuRsp.ack && !cpuRsp.allowed |-> !memWriteEn)
    else $error("refused write still committed");
  chk_pin_pullup: assert property (
    progSelectDedicated |-> !progSelectPullupEn)
    else $error("pull-up on while select pin is dedicated");
  chk_hv_entry: assert property (
    hvEntryPin [*3] |=> progMode)
    else $error("high-voltage entry not honoured");
endmodule

// *** dv/flash_array_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Program array stand-in for the far side
module flash_array_model (
  input  wire logic [21:0] addr,  // Address now requested
  output logic      [7:0]  rdata  // Same-cycle array byte
);
  // Fixed pattern in place of storage; each byte is the XOR of the two low address bytes and 5A
  assign rdata = addr[7:0] ^ addr[15:8] ^ 8'h5A;
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      nErrors++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end

// ==========================================
// Bench for the code protection unit
module testbench;
  logic                         clk = 1'b0;
  logic                         rst_b, progBlockErase, progChipErase, hvEntryPin;
  logic                         progSelectPin, memWriteEn, gotWen, progMode, debugEnable;
  logic                         progSelectDedicated, progSelectPullupEn;
  logic [2:0]                   progEraseIdx;
  logic [7:0]                   memRdata, memWdata, gotData, tableLatch;
  logic [7:0]                   cfg [6];
  logic [21:0]                  cpuPc, memAddr, arrAddr, gotAddr;
  logic [31:0]                  seed = 32'h0001807D;
  code_protect_pkg::table_req_t cpuReq, progReq;
  code_protect_pkg::table_rsp_t cpuRsp, progRsp, rsp;
  int                           nErrors = 0;
  int                           comparisons = 0;

  // 40 MHz core clock
  always #12.5 clk = ~clk;
  // Array sees whichever side currently owns the table port
  assign arrAddr = progMode ? progReq.addr : cpuReq.addr;

  flash_array_model flash_array_model_i (.addr(arrAddr), .rdata(memRdata));
  program_memory_code_protect #(.BLOCKS(4)) program_memory_code_protect_i (
    .clk(clk), .rst_b(rst_b), .cpuReq(cpuReq), .cpuPc(cpuPc), .progReq(progReq),
    .progBlockErase(progBlockErase), .progEraseIdx(progEraseIdx),
    .progChipErase(progChipErase), .hvEntryPin(hvEntryPin), .progSelectPin(progSelectPin),
    .memRdata(memRdata), .cpuRsp(cpuRsp), .progRsp(progRsp), .tableLatch(tableLatch),
    .memWriteEn(memWriteEn), .memAddr(memAddr), .memWdata(memWdata), .progMode(progMode),
    .progSelectDedicated(progSelectDedicated), .progSelectPullupEn(progSelectPullupEn),
    .debugEnable(debugEnable));

  // ==========================================
  // Expectation helpers
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] pat(input logic [21:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  // Protection block of an address, 4 is the boot block
  function automatic int blk(input logic [21:0] a);
    return a < 22'h000200 ? 4 : int'(a[14:13]);
  endfunction
  // Kind k: 0 code lock, 1 write lock, 2 cross read enable
  function automatic logic pbit(input int k, input int b);
    return b == 4 ? cfg[2 * k + 1][6] : cfg[2 * k][b];
  endfunction
  function automatic logic [7:0] mask(input int i);
    return i[0] ? (i == 1 ? 8'hC0 : i == 3 ? 8'hE0 : 8'h40) : 8'h0F;
  endfunction
  // Foreign reads of a cross-read-disabled block give zero
  function automatic logic [7:0] expRd(input logic [21:0] a, pc);
    if (a[15] || !pbit(2, blk(a)) && blk(pc) != blk(a))
      return 8'h00;
    return pat(a);
  endfunction

  // ==========================================
  // Drivers; all changes on falling edges
  task automatic access(input logic prog, rd, eep, input logic [21:0] a,
                        input logic [7:0] wd);
    @(negedge clk);
    if (prog)
      progReq = '{rd, !rd, eep, a, wd};
    else
      cpuReq = '{rd, !rd, eep, a, wd};
    @(negedge clk);
    rsp = prog ? progRsp : cpuRsp;
    {gotWen, gotAddr, gotData} = {memWriteEn, memAddr, memWdata};
    cpuReq = '0;
    progReq = '0;
  endtask
  task automatic chkRd(input logic eep, input logic [21:0] a, input logic [7:0] e);
    access(progMode, 1'b1, eep, a, 8'h00);
    `CHECK("read data", e, rsp.rdata)
    `CHECK("read ack", 1'b1, rsp.ack)
  endtask
  // Model only clears bits, and only when the config lock lets it or the programmer writes byte 3
  task automatic cfgWr(input logic prog, input int i, input logic [7:0] wd);
    logic ok;
    ok = prog ? (cfg[3][5] || i == 3) : (cfg[3][5] && i != 3);
    access(prog, 1'b0, 1'b0, 22'(22'h300008 + i), wd);
    `CHECK("config allowed", ok, rsp.allowed)
    if (ok)
      cfg[i] = cfg[i] & wd;
  endtask
  task automatic cfgCheck;
    for (int i = 0; i < 6; i++)
      chkRd(1'b0, 22'(22'h300008 + i), cfg[i] & mask(i));
  endtask
  task automatic erase(input logic chip, input int b);
    @(negedge clk);
    {progChipErase, progBlockErase, progEraseIdx} = {chip, !chip, 3'(b)};
    @(negedge clk);
    {progChipErase, progBlockErase} = 2'b00;
    if (progMode && chip)
      cfg = '{default: 8'hFF};
    else if (progMode)
      for (int k = 0; k < 6; k += 2)
        cfg[k + int'(b == 4)][b == 4 ? 6 : b] = 1'b1;
  endtask
  // Pins pass a two-stage synchroniser, so allow four edges
  task automatic setPins(input logic hv, sel);
    @(negedge clk);
    {hvEntryPin, progSelectPin} = {hv, sel};
    repeat (4) @(negedge clk);
  endtask
  task automatic randCore(input int n);
    logic [21:0] a;
    for (int i = 0; i < n; i++)
    begin
      seed = nextRand(seed);
      a = {6'h00, seed[31] & seed[15], seed[14:0]};
      cpuPc = {7'h00, seed[30:16]};
      access(1'b0, seed[31], 1'b0, a, seed[23:16]);
      if (seed[31])
      begin
        `CHECK("array read", expRd(a, cpuPc), rsp.rdata)
        `CHECK("table latch", expRd(a, cpuPc), tableLatch)
      end
      else
      begin
        `CHECK("write commit", pbit(1, blk(a)), gotWen)
        if (gotWen === 1'b1)
          `CHECK("write target", {a, seed[23:16]}, {gotAddr, gotData})
      end
    end
  endtask
  task automatic endSim;
    $display("comparisons %0d mismatches %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    cpuReq = '0;
    progReq = '0;
    cpuPc = 22'h000000;
    {progBlockErase, progChipErase, progEraseIdx} = 5'h00;
    {hvEntryPin, progSelectPin, rst_b} = 3'b000;
    cfg = '{default: 8'hFF};
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    `CHECK("pin dedicated", 1'b1, progSelectDedicated)
    `CHECK("debug enable", 1'b0, debugEnable)
    cfgCheck();
    chkRd(1'b0, 22'h300006, 8'h85);
    randCore(40);
    for (int i = 0; i < 8; i++)
    begin
      seed = nextRand(seed);
      access(1'b0, 1'b0, 1'b0, 22'(22'h200000 + i), seed[7:0]);
      chkRd(1'b0, 22'(22'h200000 + i), seed[7:0]);
    end
    $display("test open array done");
    // Low-voltage entry may not change its own option bit
    setPins(1'b0, 1'b1);
    `CHECK("low voltage entry", 1'b1, progMode)
    access(1'b1, 1'b0, 1'b0, 22'h300006, 8'h81);
    chkRd(1'b0, 22'h300006, 8'h85);
    setPins(1'b0, 1'b0);
    setPins(1'b1, 1'b0);
    `CHECK("high voltage entry", 1'b1, progMode)
    access(1'b0, 1'b1, 1'b0, 22'h000300, 8'h00);
    `CHECK("core muted", 1'b0, rsp.ack)
    cfgWr(1'b1, 4, 8'hFE);
    cfgWr(1'b1, 2, 8'hFD);
    cfgWr(1'b1, 0, 8'hF7);
    cfgWr(1'b1, 1, 8'h7F);
    cfgWr(1'b1, 4, 8'hFF);
    cfgCheck();
    chkRd(1'b0, 22'h006100, 8'h00);
    `CHECK("locked block", 1'b0, rsp.allowed)
    chkRd(1'b0, 22'h004100, pat(22'h004100));
    chkRd(1'b1, 22'h000010, 8'h00);
    access(1'b1, 1'b0, 1'b1, 22'h000010, 8'h33);
    `CHECK("eeprom write", 2'b00, {rsp.allowed, gotWen})
    access(1'b1, 1'b0, 1'b0, 22'h300006, 8'h01);
    chkRd(1'b0, 22'h300006, 8'h01);
    setPins(1'b0, 1'b0);
    `CHECK("pin released", 2'b01, {progSelectDedicated, progSelectPullupEn})
    `CHECK("debugger on", 1'b1, debugEnable)
    setPins(1'b0, 1'b1);
    `CHECK("select pin as I/O", 1'b0, progMode)
    setPins(1'b0, 1'b0);
    $display("test programming entry done");
    // Locked blocks seen from the core
    cpuPc = 22'h000300;
    chkRd(1'b0, 22'h000400, pat(22'h000400));
    cpuPc = 22'h000100;
    chkRd(1'b0, 22'h000400, 8'h00);
    randCore(80);
    access(1'b0, 1'b0, 1'b1, 22'h000010, 8'h44);
    `CHECK("core eeprom write", 1'b1, rsp.allowed)
    cfgWr(1'b0, 2, 8'hFB);
    cfgWr(1'b0, 3, 8'h00);
    erase(1'b0, 1);
    cfgCheck();
    $display("test locked core done");
    // Erase only from the programmer, and config lock
    setPins(1'b1, 1'b0);
    erase(1'b0, 1);
    erase(1'b0, 4);
    cfgCheck();
    cfgWr(1'b1, 3, 8'hDF);
    cfgWr(1'b1, 0, 8'h00);
    erase(1'b1, 0);
    cfgWr(1'b1, 3, 8'h7F);
    cfgCheck();
    access(1'b1, 1'b1, 1'b1, 22'h000020, 8'h00);
    `CHECK("eeprom read", 1'b1, rsp.allowed)
    access(1'b1, 1'b0, 1'b1, 22'h000020, 8'h55);
    `CHECK("eeprom write lock", 1'b0, rsp.allowed)
    setPins(1'b0, 1'b0);
    $display("test erase done");
    for (int j = 0; j < 4; j++)
    begin
      seed = nextRand(seed);
      cfgWr(1'b0, 2 * int'(seed[1:0] % 3), seed[15:8]);
      randCore(25);
    end
    cfgCheck();
    $display("test random locks done");
    endSim();
  end

  // Hang guard, far beyond the sequence length
  initial
  begin
    repeat (20000) @(posedge clk);
    nErrors++;
    endSim();
  end
endmodule

bind program_memory_code_protect code_protect_properties code_protect_properties_i (
  .clk(clk), .rst_b(rst_b), .cpuReq(cpuReq), .hvEntryPin(hvEntryPin), .cpuRsp(cpuRsp),
  .tableLatch(tableLatch), .memWriteEn(memWriteEn), .progMode(progMode),
  .progSelectDedicated(progSelectDedicated), .progSelectPullupEn(progSelectPullupEn));
